// File: pkg/iopte_pkg.sv
// Package: constants and carriers for the I/O processor transfer engine
package iopte_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned SYS_CYCLE_NS   = 110;
  // Longest time: one bus transfer fits in a system cycle, round down
  localparam int unsigned BUS_CYC        = (SYS_CYCLE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                           (SYS_CYCLE_NS / CLK_PERIOD_NS);
  localparam int unsigned MEM_LAT_CYC    = 3 * BUS_CYC;
  localparam logic [5:0]  DISK_CHANNEL   = 6'h28;
  localparam logic [23:0] MAILBOX_ADDR   = 24'h000010;
  localparam logic [23:0] DISK_BASE_ADDR = 24'h400000;
  localparam logic [1:0]  MOD_SEL_DFLT   = 2'h0;
  localparam logic [7:0]  CNT_RST        = 8'h00;
  localparam logic [15:0] RD_OK          = 16'h0000;
  localparam int unsigned DW             = 16;
  localparam int unsigned AW             = 24;

  typedef enum logic [8:0] {
    IOPTE_IDLE    = 9'b000000001,
    IOPTE_MB_RD   = 9'b000000010,
    IOPTE_MB_WT   = 9'b000000100,
    IOPTE_LNK_CMD = 9'b000001000,
    IOPTE_XFER_RQ = 9'b000010000,
    IOPTE_XFER_WT = 9'b000100000,
    IOPTE_DSK_RD  = 9'b001000000,
    IOPTE_RD_WR   = 9'b010000000,
    IOPTE_DONE    = 9'b100000000
  } iopte_state_e;

  typedef struct packed {
    logic          req;
    logic          we;
    logic [AW-1:0] addr;
    logic [1:0]    mod_sel;
    logic [1:0]    digit_mark;
    logic [DW-1:0] wdata;
  } iopte_mem_req_s;

  typedef struct packed {
    logic          valid;
    logic          dir_in;
    logic [5:0]    chan;
    logic [DW-1:0] data;
  } iopte_link_s;
endpackage

// File: rtl/iopte_mem_tracker.sv
// Memory completion tracker: counts decoupled memory latency per command
module iopte_mem_tracker
  import iopte_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  input  wire logic i_issue,
  output logic      o_busy,
  output logic      o_done
);
  typedef struct packed {
    logic       busy;
    logic       done;
    logic [7:0] cnt;
  } iopte_trk_s;

  iopte_trk_s st, next_st;

  // Memory decouples after accepting a command, so completion is timed here
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (i_issue && !st.busy) begin
      next_st.busy = 1'b1;
      // Done is registered and the request drops one edge later, so load two short
      next_st.cnt  = 8'(MEM_LAT_CYC - 2);
    end else if (st.busy) begin
      if (st.cnt == CNT_RST) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_busy = st.busy;
  assign o_done = st.done;

  a_trk_latency: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_issue && !o_busy) |=> o_busy [*5] ##1 o_done)
    else $error("memory completion not on time");
endmodule

// File: rtl/iopte_top.sv
// Top: I/O processor transfer engine, initiate to result descriptor
module iopte_top
  import iopte_pkg::*;
(
  input  wire logic           i_sys_clk,
  input  wire logic           i_rstn,
  input  wire logic           i_initiate,
  input  wire logic [63:0]    i_own_chan_mask,
  input  wire logic           i_mem_grant,
  input  wire logic [DW-1:0]  i_mem_rdata,
  input  wire iopte_link_s    i_link,
  input  wire logic           i_maint_din,
  input  wire logic           i_maint_load,
  output iopte_mem_req_s      o_mem,
  output iopte_link_s         o_link,
  output logic                o_link_busy,
  output logic                o_complete,
  output logic                o_ready,
  output logic                o_maint_dout
);
  typedef struct packed {
    iopte_state_e   fsm;
    iopte_mem_req_s mem;
    iopte_link_s    lnk;
    logic           link_busy;
    logic           complete;
    logic           loaded;
    logic           ready;
    logic           maint_dout;
    logic           pend_init;
    logic           is_disk;
    logic [5:0]     chan;
    logic [AW-1:0]  buf_addr;
    logic [DW-1:0]  hold;
    logic [DW-1:0]  remain;
    logic           dir_in;
    logic [DW-1:0]  result;
  } iopte_top_s;

  iopte_top_s st, next_st;
  logic       trk_busy;
  logic       trk_done;
  logic       issue;

  assign issue = next_st.mem.req && !st.mem.req;

  iopte_mem_tracker u_trk (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_issue   (issue),
    .o_busy    (trk_busy),
    .o_done    (trk_done)
  );

  always_comb begin
    next_st            = st;
    next_st.complete   = 1'b0;
    next_st.lnk.valid  = 1'b0;
    next_st.mem.digit_mark = 2'h3; // Whole 16-bit word of the wider memory word
    // Serial store load; engine idles until it is loaded
    if (i_maint_load) begin
      next_st.loaded     = 1'b1;
      next_st.maint_dout = i_maint_din;
    end
    // Initiate is latched in one flag, so one arriving while a transfer runs is kept; repeats merge
    if (i_initiate) begin
      next_st.pend_init = 1'b1;
    end
    // Memory request drops once the tracker reports completion
    if (trk_done) begin
      next_st.mem.req = 1'b0;
    end
    case (st.fsm)
      IOPTE_IDLE: begin
        if (st.loaded && st.link_busy && i_link.valid && i_link.chan == st.chan) begin
          next_st.dir_in = i_link.dir_in;
          next_st.hold   = i_link.data;
          next_st.fsm    = IOPTE_XFER_RQ;
        end else if (st.loaded && st.pend_init) begin
          // A fresh initiate in the same cycle wins over the clear
          next_st.pend_init = i_initiate;
          next_st.fsm       = IOPTE_MB_RD;
        end
      end
      IOPTE_MB_RD: begin
        if (i_mem_grant) begin
          next_st.mem.req     = 1'b1;
          next_st.mem.we      = 1'b0;
          next_st.mem.addr    = MAILBOX_ADDR;
          next_st.mem.mod_sel = MOD_SEL_DFLT;
          next_st.fsm         = IOPTE_MB_WT;
        end
      end
      IOPTE_MB_WT: begin
        if (trk_done) begin
          // Mailbox word: channel in low bits, count in the upper ten
          next_st.chan    = i_mem_rdata[5:0];
          next_st.remain  = {6'h00, i_mem_rdata[15:6]};
          next_st.is_disk = (i_mem_rdata[5:0] == DISK_CHANNEL);
          next_st.buf_addr = MAILBOX_ADDR + 24'h000001;
          if (!i_own_chan_mask[i_mem_rdata[5:0]]) begin
            next_st.fsm = IOPTE_IDLE;
          end else if (i_mem_rdata[5:0] == DISK_CHANNEL) begin
            next_st.fsm = IOPTE_DSK_RD;
          end else begin
            next_st.fsm = IOPTE_LNK_CMD;
          end
        end
      end
      IOPTE_LNK_CMD: begin
        next_st.lnk.valid  = 1'b1;
        next_st.lnk.dir_in = 1'b0;
        next_st.lnk.chan   = st.chan;
        next_st.lnk.data   = st.remain;
        next_st.link_busy  = 1'b1;
        next_st.fsm        = IOPTE_IDLE;
      end
      IOPTE_XFER_RQ: begin
        if (i_mem_grant) begin
          next_st.mem.req   = 1'b1;
          next_st.mem.we    = st.dir_in;
          next_st.mem.addr  = st.is_disk ? DISK_BASE_ADDR + st.buf_addr : st.buf_addr;
          next_st.mem.wdata = st.hold;
          next_st.fsm       = IOPTE_XFER_WT;
        end
      end
      IOPTE_XFER_WT: begin
        if (trk_done) begin
          next_st.buf_addr = st.buf_addr + 24'h000001;
          next_st.remain   = st.remain - 16'h0001;
          if (!st.dir_in && !st.is_disk) begin
            next_st.lnk.valid  = 1'b1;
            next_st.lnk.dir_in = 1'b0;
            next_st.lnk.chan   = st.chan;
            next_st.lnk.data   = i_mem_rdata;
          end
          if (st.remain <= 16'h0001) begin
            next_st.fsm = IOPTE_RD_WR;
          end else if (st.is_disk) begin
            next_st.hold = i_mem_rdata;
            next_st.fsm  = IOPTE_XFER_RQ;
          end else begin
            next_st.fsm = IOPTE_IDLE; // Wait for the next reconnection
          end
        end
      end
      IOPTE_DSK_RD: begin
        // Emulated disk: data stays in memory, direction always outbound (dir_in cleared)
        next_st.dir_in = 1'b0;
        next_st.fsm    = (st.remain == 16'h0000) ? IOPTE_RD_WR : IOPTE_XFER_RQ;
      end
      IOPTE_RD_WR: begin
        if (i_mem_grant && !trk_busy && !st.mem.req) begin
          next_st.mem.req   = 1'b1;
          next_st.mem.we    = 1'b1;
          next_st.mem.addr  = MAILBOX_ADDR + 24'h000002;
          next_st.mem.wdata = st.result;
          next_st.fsm       = IOPTE_DONE;
        end
      end
      IOPTE_DONE: begin
        if (trk_done) begin
          next_st.complete  = 1'b1;
          next_st.link_busy = 1'b0;
          next_st.fsm       = IOPTE_IDLE;
        end
      end
      default: next_st.fsm = IOPTE_IDLE;
    endcase
    next_st.ready = next_st.loaded && (next_st.fsm == IOPTE_IDLE);
  end

  // Memory bus is driven only from a registered request, never combinationally
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st        <= '0;
      st.fsm    <= IOPTE_IDLE;
      st.result <= RD_OK;
    end else begin
      st <= next_st;
    end
  end

  assign o_mem        = st.mem;
  assign o_link       = st.lnk;
  assign o_link_busy  = st.link_busy;
  assign o_complete   = st.complete;
  assign o_ready      = st.ready;
  assign o_maint_dout = st.maint_dout;

  a_grant_drive: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    $rose(o_mem.req) |-> $past(i_mem_grant))
    else $error("address bus driven without grant");
  a_init_mailbox: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (st.fsm == IOPTE_MB_RD && i_mem_grant) |=> o_mem.req && o_mem.addr == MAILBOX_ADDR)
    else $error("mailbox not read after initiate");
  a_disconnect: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (st.fsm == IOPTE_LNK_CMD) |=> o_link.valid && o_ready)
    else $error("no disconnect after link command");
  a_complete_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    o_complete |=> !o_complete && !o_link_busy)
    else $error("completion not a clean pulse");
  a_disk_no_link: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    st.is_disk && st.fsm == IOPTE_XFER_WT |-> !o_link.valid)
    else $error("disk channel used the link");
  a_result_first: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    $rose(o_complete) |-> $past(st.fsm) == IOPTE_DONE)
    else $error("completion without result write");
  a_foreign_chan: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (st.fsm == IOPTE_MB_WT && trk_done && !i_own_chan_mask[i_mem_rdata[5:0]])
      |=> st.fsm == IOPTE_IDLE)
    else $error("foreign channel accepted");
  a_unloaded_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !st.loaded |-> st.fsm == IOPTE_IDLE && !o_mem.req)
    else $error("engine ran before store load");
  a_req_bounded: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    $rose(o_mem.req) |-> o_mem.req [*6] ##1 !o_mem.req)
    else $error("memory request outlived its cycle");

  c_link_op:  cover property (@(posedge i_sys_clk) st.fsm == IOPTE_LNK_CMD);
  c_disk_op:  cover property (@(posedge i_sys_clk) st.is_disk && o_complete);
  c_link_end: cover property (@(posedge i_sys_clk) !st.is_disk && o_complete);
  c_link_out: cover property (@(posedge i_sys_clk) st.fsm == IOPTE_XFER_WT && !st.dir_in
                                && !st.is_disk && trk_done);
  c_foreign:  cover property (@(posedge i_sys_clk) st.fsm == IOPTE_MB_WT && trk_done
                                && !i_own_chan_mask[i_mem_rdata[5:0]]);
endmodule

// File: sim/iopte_dlp_model.sv
// Data link processor model answering link commands with words whose direction follows i_dir
module iopte_dlp_model
  import iopte_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire iopte_link_s i_cmd,
  input  wire logic        i_mem_req,
  input  wire logic        i_dir,
  input  wire logic [15:0] i_base,
  input  wire logic [3:0]  i_gap,
  output iopte_link_s      o_link
);
  timeunit 1ns;
  timeprecision 1ns;
  int          n;
  logic [5:0]  ch;
  logic [15:0] cnt;
  // Released bus toggles each cycle so a stale word never looks valid
  task automatic idle(input int c);
    repeat (c) begin
      @(negedge i_sys_clk);
      o_link.data = ~o_link.data;
    end
  endtask
  initial begin
    o_link = '0;
    forever begin
      idle(1);
      if (i_cmd.valid === 1'b1) begin
        ch = i_cmd.chan;
        cnt = i_cmd.data;
        for (int k = 0; k < int'(cnt); k++) begin
          idle(int'(i_gap));
          o_link = '{1'b1, i_dir, ch, i_base + 16'(k)};
          @(negedge i_sys_clk);
          o_link.valid = 1'b0;
          n = 0;
          // Next word only after the engine finished its memory request
          while (i_mem_req !== 1'b1 && n < 40) begin
            idle(1);
            n++;
          end
          while (i_mem_req === 1'b1 && n < 80) begin
            idle(1);
            n++;
          end
        end
      end
    end
  end
endmodule

// File: sim/test_io_processor_transfer_engine.sv
// Self-checking bench for the transfer engine with a link partner model
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module test_io_processor_transfer_engine
  import iopte_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic           i_sys_clk = 1'b0, i_rstn = 1'b0, i_initiate = 1'b0;
  logic           i_mem_grant = 1'b0, i_maint_din = 1'b0, i_maint_load = 1'b0;
  logic [63:0]    i_own_chan_mask = '0;
  logic [DW-1:0]  i_mem_rdata = '0, mbox = '0, base = '0, key = '0;
  logic [3:0]     gap = 4'h3;
  logic [31:0]    rnd = 32'hE625;
  iopte_link_s    i_link, o_link;
  iopte_mem_req_s o_mem;
  logic           o_link_busy, o_complete, o_ready, o_maint_dout;
  logic           prev_req = 1'b0, gr_prev = 1'b0, want_mb = 1'b0, track = 1'b0, dir = 1'b1;
  int             bad_count = 0, checked = 0, len = 0, cdone = 0, rdy_at = 0;
  logic [43:0]    q[$];
  always #20 i_sys_clk = ~i_sys_clk;
  iopte_top dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_initiate(i_initiate),
    .i_own_chan_mask(i_own_chan_mask), .i_mem_grant(i_mem_grant),
    .i_mem_rdata(i_mem_rdata), .i_link(i_link), .i_maint_din(i_maint_din),
    .i_maint_load(i_maint_load), .o_mem(o_mem), .o_link(o_link),
    .o_link_busy(o_link_busy), .o_complete(o_complete), .o_ready(o_ready),
    .o_maint_dout(o_maint_dout));
  iopte_dlp_model dlp (.i_sys_clk(i_sys_clk), .i_cmd(o_link), .i_mem_req(o_mem.req),
    .i_dir(dir), .i_base(base), .i_gap(gap), .o_link(i_link));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic tally_and_finish;
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // An empty queue yields kind F, so any unexpected event mismatches
  task automatic take(input logic [3:0] k, input logic [23:0] a, input logic [15:0] d);
    logic [43:0] n;
    n = (q.size() == 0) ? '1 : q.pop_front();
    `CHK(k, n[43:40])
    `CHK(d, n[15:0])
    if (n[39:16] != 24'hFFFFFF) `CHK(a, n[39:16])
  endtask
  // Random grant gaps keep the shared address bus contended
  always @(negedge i_sys_clk) begin
    rnd <= xs(rnd);
    i_mem_grant <= rnd[0] | rnd[1];
    // Memory hands back a 16-bit slice of its wider word, keyed by address
    i_mem_rdata <= (o_mem.addr === MAILBOX_ADDR) ? mbox : (o_mem.addr[15:0] ^ key);
  end
  always @(posedge i_sys_clk) begin
    if (i_rstn) begin
      if (o_mem.req === 1'b1 && !prev_req) begin
        `CHK(gr_prev, 1'b1)
        `CHK(o_mem.digit_mark, 2'h3)
        if (o_mem.we === 1'b1) take(4'h2, o_mem.addr, o_mem.wdata);
        if (!o_mem.we && want_mb) `CHK(o_mem.addr, MAILBOX_ADDR)
        else if (!o_mem.we) `CHK(o_mem.addr >= DISK_BASE_ADDR, !track)
        if (!o_mem.we) want_mb = 1'b0;
      end
      if (o_mem.req !== 1'b1 && prev_req) `CHK(len, MEM_LAT_CYC)
      len = (o_mem.req === 1'b1) ? len + 1 : 0;
      if (rdy_at == 1) begin
        `CHK(o_ready, 1'b1)
        `CHK(o_link_busy, 1'b1)
      end
      if (rdy_at > 0) rdy_at--;
      if (o_link.valid === 1'b1) begin
        // Only a link command, not an outbound data word, is checked for a following idle
        if (!prev_req) rdy_at = 3;
        take(4'h1, {18'h0, o_link.chan}, o_link.data);
      end
      if (o_complete === 1'b1) begin
        take(4'h3, 24'hFFFFFF, 16'h0);
        cdone++;
      end
    end
    prev_req = (o_mem.req === 1'b1);
    gr_prev = i_mem_grant;
  end
  task automatic op(input logic [5:0] ch, input logic [9:0] cnt, input bit own, input bit din);
    int n;
    mbox = {cnt, ch};
    base = rnd[15:0];
    key = rnd[31:16];
    dir = din;
    gap = 4'h3 + rnd[18:16];
    track = own && (ch != DISK_CHANNEL);
    want_mb = 1'b1;
    if (track) q.push_back({4'h1, 18'h0, ch, 6'h0, cnt});
    // Inbound words come back as writes, outbound ones as link words
    for (int k = 0; k < int'(cnt) && track; k++) begin
      if (din) q.push_back({4'h2, 24'hFFFFFF, base + 16'(k)});
      else q.push_back({4'h1, 18'h0, ch, key ^ 16'(MAILBOX_ADDR + 24'(k + 1))});
    end
    if (own) q.push_back({4'h2, 24'h000012, RD_OK});
    if (own) q.push_back({4'h3, 24'hFFFFFF, 16'h0});
    n = cdone;
    @(negedge i_sys_clk) i_initiate = 1'b1;
    @(negedge i_sys_clk) i_initiate = 1'b0;
    for (int t = 0; t < 600 && cdone == n; t++) @(negedge i_sys_clk);
    repeat (30) @(negedge i_sys_clk);
    `CHK(q.size(), 0)
    `CHK(o_link_busy, 1'b0)
  endtask
  initial begin
    #400000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge i_sys_clk);
    @(negedge i_sys_clk) i_rstn = 1'b1;
    i_own_chan_mask = {rnd, rnd} | (64'h1 << 5) | (64'h1 << 7) | (64'h1 << 40);
    i_own_chan_mask[9] = 1'b0;
    @(negedge i_sys_clk);
    `CHK(o_complete, 1'b0)
    `CHK(o_ready, 1'b0)
    i_maint_din = 1'b1;
    i_maint_load = 1'b1;
    @(negedge i_sys_clk) i_maint_load = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    `CHK(o_ready, 1'b1)
    `CHK(o_maint_dout, 1'b1)
    op(6'd5, 10'd1, 1'b1, 1'b1);
    op(6'd7, 10'd3, 1'b1, 1'b1);
    op(6'd7, 10'd3, 1'b1, 1'b0);
    op(DISK_CHANNEL, 10'd2, 1'b1, 1'b1);
    op(6'd9, 10'd2, 1'b0, 1'b1);
    repeat (3) op(rnd[0] ? 6'd5 : 6'd7, 10'd1 + rnd[9:8], 1'b1, rnd[2]);
    tally_and_finish;
  end
endmodule
